// ---- pkg/pmdb_pkg.sv ----
//----------------------------------------------------------------------
// Package
//----------------------------------------------------------------------
// Purpose: Constants and carrier types of the peripheral disable bank.
// Assumes: 100 MHz system clock, classic Wishbone with 32-bit data.
// Notes:   Register indices are kept as printed; byte address is 4x.
package pmdb_pkg;

	// -----------------------------------------------------------------
	// Bus geometry
	// -----------------------------------------------------------------
	localparam int WB_ADR_W  = 16;
	localparam int WB_DATA_W = 32;
	localparam int IDX_W     = 12;
	localparam int REG_W     = 8;
	localparam int REG_COUNT = 6;

	// -----------------------------------------------------------------
	// Register indices and reset values
	// -----------------------------------------------------------------
	localparam logic [IDX_W-1:0] PERIPHERAL_DISABLE_0_IDX = 12'hEDC;
	localparam logic [IDX_W-1:0] PERIPHERAL_DISABLE_1_IDX = 12'hEDD;
	localparam logic [IDX_W-1:0] PERIPHERAL_DISABLE_2_IDX = 12'hEDE;
	localparam logic [IDX_W-1:0] PERIPHERAL_DISABLE_3_IDX = 12'hEDF;
	localparam logic [IDX_W-1:0] PERIPHERAL_DISABLE_4_IDX = 12'hEE0;
	localparam logic [IDX_W-1:0] PERIPHERAL_DISABLE_5_IDX = 12'hEE1;
	localparam logic [REG_W-1:0] DISABLE_RESET = 8'h00;
	// Implemented bits per register, register 5 first
	localparam logic [REG_COUNT-1:0][REG_W-1:0] IMPL_MASK =
		{8'hF1, 8'hF1, 8'hFF, 8'h67, 8'h7F, 8'hFF};

	// -----------------------------------------------------------------
	// Field positions
	// -----------------------------------------------------------------
	localparam int SYS_CLOCK_NET_OFF_BIT   = 7;
	localparam int FIXED_VREF_OFF_BIT      = 6;
	localparam int VOLT_DETECT_OFF_BIT     = 5;
	localparam int CHECKSUM_ENGINE_OFF_BIT = 4;
	localparam int MEM_SCANNER_OFF_BIT     = 3;
	localparam int NONVOL_MEM_OFF_BIT      = 2;
	localparam int CLOCK_REF_OUT_OFF_BIT   = 1;
	localparam int PIN_CHANGE_IRQ_OFF_BIT  = 0;
	localparam int TIMER_OFF_MSB           = 6;
	localparam int DAC_UNIT_OFF_BIT        = 6;
	localparam int ADC_UNIT_OFF_BIT        = 5;
	localparam int COMPARATOR_OFF_MSB      = 2;
	localparam int COMPARATOR_OFF_LSB      = 1;
	localparam int ZERO_CROSS_OFF_BIT      = 0;
	localparam int LOGIC_CELL_OFF_MSB      = 7;
	localparam int LOGIC_CELL_OFF_LSB      = 4;
	localparam int PULSE_MOD_OFF_MSB       = 3;
	localparam int PULSE_MOD_OFF_LSB       = 2;
	localparam int CAPTURE_UNIT_OFF_MSB    = 1;
	localparam int SERIAL_PORT_OFF_MSB     = 7;
	localparam int SERIAL_PORT_OFF_LSB     = 6;
	localparam int SYNC_SERIAL_OFF_MSB     = 5;
	localparam int SYNC_SERIAL_OFF_LSB     = 4;
	localparam int WAVEFORM_UNIT_OFF_BIT   = 0;
	localparam int SIGNAL_MODULATOR_OFF_BIT = 0;

	// -----------------------------------------------------------------
	// Timing
	// -----------------------------------------------------------------
	localparam int CLOCK_PERIOD_NS      = 10;
	localparam int INSTR_CLOCK_DIV      = 4;
	localparam int REENABLE_GUARD_INSTR = 2;
	localparam int REENABLE_GUARD_CYCLES =
		INSTR_CLOCK_DIV * REENABLE_GUARD_INSTR;
	localparam int NONVOL_WAKE_NS       = 1000;
	localparam int NONVOL_WAKE_CYCLES_RAW = NONVOL_WAKE_NS / CLOCK_PERIOD_NS;
	localparam int NONVOL_WAKE_CYCLES   =
		(NONVOL_WAKE_CYCLES_RAW < 1) ? 1 : NONVOL_WAKE_CYCLES_RAW;

	// -----------------------------------------------------------------
	// Carriers
	// -----------------------------------------------------------------
	// One bit per peripheral; vectors are indexed by unit number minus 1
	typedef struct packed {
		logic       sysClockNetOff;
		logic       fixedVrefOff;
		logic       voltDetectOff;
		logic       checksumEngineOff;
		logic       memScannerOff;
		logic       nonvolMemOff;
		logic       clockRefOutOff;
		logic       pinChangeIrqOff;
		logic [6:0] timerOff;
		logic       dacUnitOff;
		logic       adcUnitOff;
		logic [1:0] comparatorOff;
		logic       zeroCrossOff;
		logic [7:0] logicCellOff;
		logic [1:0] pulseModOff;
		logic [1:0] captureUnitOff;
		logic [1:0] serialPortOff;
		logic [1:0] syncSerialOff;
		logic       waveformUnitOff;
		logic       signalModulatorOff;
	} pmdb_off_t;

	localparam int OFF_W = $bits(pmdb_off_t);

	typedef struct packed {
		logic             write;
		logic [IDX_W-1:0] index;
		logic             hit;
		logic [REG_W-1:0] wdata;
	} pmdb_cmd_t;

	typedef struct packed {
		logic             ack;
		logic [REG_W-1:0] rdata;
	} pmdb_slave_state_t;

	typedef struct packed {
		logic [REG_COUNT-1:0][REG_W-1:0] regs;
		pmdb_off_t                       off;
		logic [1:0]                      divCount;
		logic                            instrTick;
		logic                            sysClockNetEnable;
	} pmdb_top_state_t;

endpackage

// ---- design/pmdb_wb_slave.sv ----
//----------------------------------------------------------------------
// Wishbone slave
//----------------------------------------------------------------------
// Purpose: Classic Wishbone slave front end for the disable bank.
// Assumes: Master holds the request until it samples ack.
// Notes:   Ack one cycle after the request, then dropped for one cycle.
`timescale 1ns/1ps
module pmdb_wb_slave (
	input  wire logic                               clock,
	input  wire logic                               rst_n,
	input  wire logic                               ce,
	input  wire logic                               cyc_i,
	input  wire logic                               stb_i,
	input  wire logic                               we_i,
	input  wire logic [pmdb_pkg::WB_ADR_W-1:0]      adr_i,
	input  wire logic [3:0]                         sel_i,
	input  wire logic [pmdb_pkg::WB_DATA_W-1:0]     dat_i,
	output logic [pmdb_pkg::WB_DATA_W-1:0]          dat_o,
	output logic                                    ack_o,
	input  wire logic [pmdb_pkg::REG_W-1:0]         readValue,
	output pmdb_pkg::pmdb_cmd_t                     cmd
);
	pmdb_pkg::pmdb_slave_state_t state;
	pmdb_pkg::pmdb_slave_state_t next_state;
	logic                        request;

	assign request = cyc_i && stb_i;

	always_comb begin
		next_state = state;
		if (ce) begin
			next_state.ack = request && !state.ack;
			if (request && !state.ack) begin
				next_state.rdata = readValue;
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	// Upper address bits must be zero; the low two are ignored, sel_i[0] gates writes
	always_comb begin
		cmd.index = adr_i[pmdb_pkg::IDX_W+1:2];
		cmd.hit   = (adr_i[pmdb_pkg::WB_ADR_W-1:pmdb_pkg::IDX_W+2] == '0)
			&& (cmd.index >= pmdb_pkg::PERIPHERAL_DISABLE_0_IDX)
			&& (cmd.index <= pmdb_pkg::PERIPHERAL_DISABLE_5_IDX);
		// Writes land on the edge where the master sees ack
		cmd.write = ce && request && we_i && sel_i[0] && state.ack;
		cmd.wdata = dat_i[pmdb_pkg::REG_W-1:0];
	end

	assign ack_o = state.ack;
	assign dat_o = {{(pmdb_pkg::WB_DATA_W - pmdb_pkg::REG_W){1'b0}},
		state.rdata};

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	a_ack_one_cycle: assert property (
		ce && ack_o |=> !ack_o)
		else $error("ack held longer than one cycle");
	a_ack_follows_req: assert property (
		ce && request && !ack_o |=> ack_o)
		else $error("request not answered in one cycle");
endmodule // pmdb_wb_slave

// ---- design/pmdb_settle_timer.sv ----
//----------------------------------------------------------------------
// Re-enable settle timer
//----------------------------------------------------------------------
// Purpose: Per-bit ready flags that stay low while a unit is disabled
//          and for a fixed settle time after it is re-enabled.
// Assumes: offBits come from flops on the same clock.
// Notes:   Ready is advisory; software still owns the waiting.
`timescale 1ns/1ps
module pmdb_settle_timer #(
	parameter int WIDTH = 1,
	parameter int COUNT = 8
) (
	input  wire logic             clock,
	input  wire logic             rst_n,
	input  wire logic             ce,
	input  wire logic [WIDTH-1:0] offBits,
	output logic [WIDTH-1:0]      ready
);
	localparam int CNT_W = $clog2(COUNT + 1);
	localparam logic [CNT_W-1:0] LOAD = CNT_W'(COUNT);

	typedef struct packed {
		logic [WIDTH-1:0][CNT_W-1:0] count;
		logic [WIDTH-1:0]            ready;
	} pmdb_settle_state_t;

	pmdb_settle_state_t state;
	pmdb_settle_state_t next_state;

	always_comb begin
		next_state = state;
		if (ce) begin
			for (int i = 0; i < WIDTH; i++) begin
				if (offBits[i]) begin
					next_state.count[i] = LOAD;
				end else if (state.count[i] != '0) begin
					next_state.count[i] = state.count[i] - 1'b1;
				end
				next_state.ready[i] = !offBits[i]
					&& (next_state.count[i] == '0);
			end
		end
	end

	// Units start enabled and ready after reset
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state <= '0;
			state.ready <= '1;
		end else begin
			state <= next_state;
		end
	end

	assign ready = state.ready;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	a_off_not_ready: assert property (
		ce && offBits[0] |=> !ready[0])
		else $error("disabled unit reported ready");

	sequence s_release;
		ce && $fell(offBits[0]);
	endsequence
	a_settle_wait: assert property (
		s_release ##0 ce[*2] |-> !ready[0])
		else $error("ready rose before settle time");
endmodule // pmdb_settle_timer

// ---- design/pmdb_top.sv ----
//----------------------------------------------------------------------
// Peripheral disable bank
//----------------------------------------------------------------------
// Purpose: Six software registers that hold peripherals disabled and
//          gate the full-rate clock network to the peripherals.
// Assumes: Configuration-word bits are stable flops on this clock.
// Notes:   Outputs are registered; disables follow a write by one edge, ready flags drop one edge later and rise after the settle time.
`timescale 1ns/1ps
module pmdb_top (
	input  wire logic                           clock,
	input  wire logic                           rst_n,
	input  wire logic                           ce,
	input  wire logic                           cyc_i,
	input  wire logic                           stb_i,
	input  wire logic                           we_i,
	input  wire logic [pmdb_pkg::WB_ADR_W-1:0]  adr_i,
	input  wire logic [3:0]                     sel_i,
	input  wire logic [pmdb_pkg::WB_DATA_W-1:0] dat_i,
	output logic [pmdb_pkg::WB_DATA_W-1:0]      dat_o,
	output logic                                ack_o,
	input  wire logic                           scannerConfigEnable,
	input  wire logic                           zeroCrossConfig,
	output pmdb_pkg::pmdb_off_t                 periphOff,
	output pmdb_pkg::pmdb_off_t                 periphReady,
	output logic                                sysClockNetEnable,
	output logic                                instrClockTick,
	output logic                                nonvolAccessBlock,
	output logic                                nonvolCtrlWriteBlock,
	output logic                                nonvolReady
);
	// -----------------------------------------------------------------
	// Bus front end
	// -----------------------------------------------------------------
	pmdb_pkg::pmdb_cmd_t          cmd;
	logic [pmdb_pkg::REG_W-1:0]   readValue;
	logic [2:0]                   regNum;
	pmdb_pkg::pmdb_top_state_t    state;
	pmdb_pkg::pmdb_top_state_t    next_state;
	logic [pmdb_pkg::OFF_W-1:0]   readyBits;

	pmdb_wb_slave u_slave (
		.clock     (clock),
		.rst_n     (rst_n),
		.ce        (ce),
		.cyc_i     (cyc_i),
		.stb_i     (stb_i),
		.we_i      (we_i),
		.adr_i     (adr_i),
		.sel_i     (sel_i),
		.dat_i     (dat_i),
		.dat_o     (dat_o),
		.ack_o     (ack_o),
		.readValue (readValue),
		.cmd       (cmd)
	);

	assign regNum = 3'(cmd.index - pmdb_pkg::PERIPHERAL_DISABLE_0_IDX);

	// unmapped addresses and unused bits read zero
	always_comb begin
		readValue = '0;
		if (cmd.hit) begin
			readValue = state.regs[regNum] & pmdb_pkg::IMPL_MASK[regNum];
		end
	end

	// -----------------------------------------------------------------
	// Register bits to per-unit disables
	// -----------------------------------------------------------------
	function automatic pmdb_pkg::pmdb_off_t mapOff(
		input logic [pmdb_pkg::REG_COUNT-1:0][pmdb_pkg::REG_W-1:0] r,
		input logic scanCfg,
		input logic zeroCrossCfg
	);
		pmdb_pkg::pmdb_off_t o;
		o = '0;
		o.sysClockNetOff    = r[0][pmdb_pkg::SYS_CLOCK_NET_OFF_BIT];
		o.fixedVrefOff      = r[0][pmdb_pkg::FIXED_VREF_OFF_BIT];
		o.voltDetectOff     = r[0][pmdb_pkg::VOLT_DETECT_OFF_BIT];
		o.checksumEngineOff = r[0][pmdb_pkg::CHECKSUM_ENGINE_OFF_BIT];
		o.clockRefOutOff    = r[0][pmdb_pkg::CLOCK_REF_OUT_OFF_BIT];
		o.pinChangeIrqOff   = r[0][pmdb_pkg::PIN_CHANGE_IRQ_OFF_BIT];
		// scanner is off whenever its config word is clear
		o.memScannerOff = r[0][pmdb_pkg::MEM_SCANNER_OFF_BIT] || !scanCfg;
		o.nonvolMemOff      = r[0][pmdb_pkg::NONVOL_MEM_OFF_BIT];
		o.timerOff          = r[1][pmdb_pkg::TIMER_OFF_MSB:0];
		o.dacUnitOff        = r[2][pmdb_pkg::DAC_UNIT_OFF_BIT];
		o.adcUnitOff        = r[2][pmdb_pkg::ADC_UNIT_OFF_BIT];
		o.comparatorOff = r[2][pmdb_pkg::COMPARATOR_OFF_MSB:
			pmdb_pkg::COMPARATOR_OFF_LSB];
		// zero-cross bit acts only when config allows it
		o.zeroCrossOff = r[2][pmdb_pkg::ZERO_CROSS_OFF_BIT] && zeroCrossCfg;
		// cells 8..5 live in register 3
		// cells 4..1 live in register 5
		o.logicCellOff = {
			r[3][pmdb_pkg::LOGIC_CELL_OFF_MSB:pmdb_pkg::LOGIC_CELL_OFF_LSB],
			r[5][pmdb_pkg::LOGIC_CELL_OFF_MSB:pmdb_pkg::LOGIC_CELL_OFF_LSB]};
		o.pulseModOff = r[3][pmdb_pkg::PULSE_MOD_OFF_MSB:
			pmdb_pkg::PULSE_MOD_OFF_LSB];
		o.captureUnitOff = r[3][pmdb_pkg::CAPTURE_UNIT_OFF_MSB:0];
		o.serialPortOff = r[4][pmdb_pkg::SERIAL_PORT_OFF_MSB:
			pmdb_pkg::SERIAL_PORT_OFF_LSB];
		o.syncSerialOff = r[4][pmdb_pkg::SYNC_SERIAL_OFF_MSB:
			pmdb_pkg::SYNC_SERIAL_OFF_LSB];
		o.waveformUnitOff    = r[4][pmdb_pkg::WAVEFORM_UNIT_OFF_BIT];
		o.signalModulatorOff = r[5][pmdb_pkg::SIGNAL_MODULATOR_OFF_BIT];
		return o;
	endfunction

	// -----------------------------------------------------------------
	// State update
	// -----------------------------------------------------------------
	always_comb begin
		next_state = state;
		if (ce) begin
			// only implemented bits take a write
			if (cmd.write && cmd.hit) begin
				next_state.regs[regNum] =
					cmd.wdata & pmdb_pkg::IMPL_MASK[regNum];
			end
			next_state.off = mapOff(next_state.regs, scannerConfigEnable,
				zeroCrossConfig);
			// gate the full-rate network to the peripherals
			next_state.sysClockNetEnable = !next_state.off.sysClockNetOff;
			next_state.divCount  = state.divCount + 2'h1;
			next_state.instrTick = (state.divCount == 2'h3);
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state <= '0;
			state.sysClockNetEnable <= 1'b1;
		end else begin
			state <= next_state;
		end
	end

	// -----------------------------------------------------------------
	// Outputs
	// -----------------------------------------------------------------
	// disable holds the unit in reset and blocks its registers
	assign periphOff         = state.off;
	assign sysClockNetEnable = state.sysClockNetEnable;
	assign instrClockTick    = state.instrTick;
	// memory access and control-register writes blocked
	assign nonvolAccessBlock    = state.off.nonvolMemOff;
	assign nonvolCtrlWriteBlock = state.off.nonvolMemOff;

	pmdb_settle_timer #(
		.WIDTH (pmdb_pkg::OFF_W),
		.COUNT (pmdb_pkg::REENABLE_GUARD_CYCLES)
	) u_unit_settle (
		.clock   (clock),
		.rst_n   (rst_n),
		.ce      (ce),
		.offBits (state.off),
		.ready   (readyBits)
	);
	assign periphReady = readyBits;

	// memory wake time; a longer wait than the unit guard
	pmdb_settle_timer #(
		.WIDTH (1),
		.COUNT (pmdb_pkg::NONVOL_WAKE_CYCLES)
	) u_nonvol_settle (
		.clock   (clock),
		.rst_n   (rst_n),
		.ce      (ce),
		.offBits (state.off.nonvolMemOff),
		.ready   (nonvolReady)
	);

	// -----------------------------------------------------------------
	// Checks
	// -----------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	sequence s_commit(logic [pmdb_pkg::IDX_W-1:0] idx);
		ce && cmd.write && cmd.hit && cmd.index == idx;
	endsequence

	a_clock_net_gate: assert property (
		s_commit(pmdb_pkg::PERIPHERAL_DISABLE_0_IDX) ##0 cmd.wdata[7]
		|=> !sysClockNetEnable && periphOff.sysClockNetOff)
		else $error("clock network not gated after write");
	a_instr_free_run: assert property (
		instrClockTick ##1 ce[*4] |-> instrClockTick)
		else $error("instruction tick lost its period");
	a_nonvol_block: assert property (
		s_commit(pmdb_pkg::PERIPHERAL_DISABLE_0_IDX) ##0 cmd.wdata[2]
		|=> nonvolAccessBlock && nonvolCtrlWriteBlock)
		else $error("memory access not blocked");
	a_timer_map: assert property (
		s_commit(pmdb_pkg::PERIPHERAL_DISABLE_1_IDX)
		|=> periphOff.timerOff == $past(cmd.wdata[6:0]))
		else $error("timer disables do not match write");
	a_scan_qualify: assert property (
		$past(ce) && !$past(scannerConfigEnable)
		|-> periphOff.memScannerOff)
		else $error("scanner on while config disables it");
	a_zcd_qualify: assert property (
		$past(ce) && !$past(zeroCrossConfig) |-> !periphOff.zeroCrossOff)
		else $error("zero-cross disabled against config");
	a_unused_zero: assert property (
		cmd.hit && cmd.index == pmdb_pkg::PERIPHERAL_DISABLE_2_IDX
		|-> readValue[7] == 1'b0 && readValue[4:3] == 2'h0)
		else $error("unimplemented bits read nonzero");
	// Own disable: the default one would mute this check in reset
	a_reset_clear: assert property (
		@(posedge clock) disable iff (1'b0)
		!rst_n && $past(!rst_n) |-> periphOff == '0 && sysClockNetEnable)
		else $error("disables not clear in reset");
	a_cells_map: assert property (
		s_commit(pmdb_pkg::PERIPHERAL_DISABLE_5_IDX)
		|=> periphOff.logicCellOff[3:0] == $past(cmd.wdata[7:4])
		&& periphOff.signalModulatorOff == $past(cmd.wdata[0]))
		else $error("register 5 map wrong");

	// Register map checks for registers 0, 2, 3 and 4; registers 1 and 5 are checked above
	a_misc_map: assert property (
		s_commit(pmdb_pkg::PERIPHERAL_DISABLE_0_IDX)
		|=> {periphOff.fixedVrefOff, periphOff.voltDetectOff,
		periphOff.checksumEngineOff, periphOff.clockRefOutOff,
		periphOff.pinChangeIrqOff}
		== {$past(cmd.wdata[6:4]), $past(cmd.wdata[1:0])})
		else $error("register 0 unit map wrong");
	a_scan_follow: assert property (
		s_commit(pmdb_pkg::PERIPHERAL_DISABLE_0_IDX) ##0 scannerConfigEnable
		|=> periphOff.memScannerOff == $past(cmd.wdata[3]))
		else $error("scanner disable does not follow write");
	a_analog_map: assert property (
		s_commit(pmdb_pkg::PERIPHERAL_DISABLE_2_IDX) ##0 zeroCrossConfig
		|=> {periphOff.dacUnitOff, periphOff.adcUnitOff,
		periphOff.comparatorOff, periphOff.zeroCrossOff}
		== {$past(cmd.wdata[6:5]), $past(cmd.wdata[2:0])})
		else $error("register 2 map wrong");
	a_reg3_map: assert property (
		s_commit(pmdb_pkg::PERIPHERAL_DISABLE_3_IDX)
		|=> {periphOff.logicCellOff[7:4], periphOff.pulseModOff,
		periphOff.captureUnitOff} == $past(cmd.wdata))
		else $error("register 3 map wrong");
	a_reg4_map: assert property (
		s_commit(pmdb_pkg::PERIPHERAL_DISABLE_4_IDX)
		|=> {periphOff.serialPortOff, periphOff.syncSerialOff,
		periphOff.waveformUnitOff}
		== {$past(cmd.wdata[7:4]), $past(cmd.wdata[0])})
		else $error("register 4 map wrong");

	// Ready handshake seen at the outputs, timer 0 as the sample unit
	a_off_blocks_ready: assert property (
		ce && periphOff.timerOff[0] |=> !periphReady.timerOff[0])
		else $error("disabled timer reported ready");

	sequence s_timer_release;
		ce && $fell(periphOff.timerOff[0]);
	endsequence
	sequence s_timer_quiet;
		(ce && !periphOff.timerOff[0])[*7];
	endsequence
	a_ready_returns: assert property (
		s_timer_release ##1 s_timer_quiet |=> periphReady.timerOff[0])
		else $error("timer not ready after settle time");

	// Memory must not look ready on the edge it is enabled
	a_nonvol_wake: assert property (
		ce && $fell(nonvolAccessBlock) |-> !nonvolReady)
		else $error("memory ready without wake time");
endmodule // pmdb_top

// ---- bench/pmdb_bench.sv ----
//----------------------------------------------------------------------
// Peripheral disable bank bench
//----------------------------------------------------------------------
// Purpose: Self-checking bench driving the bank over classic Wishbone.
// Assumes: ce held high; configuration bits are driven by the bench.
// Notes:   The expected disable vector is rebuilt here from the bit map.
`timescale 1ns/1ps
module pmdb_bench;
	logic                            clock;
	logic                            rst_n;
	logic                            ce;
	logic                            cyc_i;
	logic                            stb_i;
	logic                            we_i;
	logic [15:0]                     adr_i;
	logic [3:0]                      sel_i;
	logic [31:0]                     dat_i;
	logic [31:0]                     dat_o;
	logic                            ack_o;
	logic                            scan;
	logic                            zc;
	pmdb_pkg::pmdb_off_t             periphOff;
	pmdb_pkg::pmdb_off_t             periphReady;
	logic                            sysClockNetEnable;
	logic                            instrClockTick;
	logic                            nvBlock;
	logic                            nvCtrlBlock;
	logic                            nvReady;
	logic [5:0][7:0]                 shadow;
	logic [7:0]                      rd;
	int                              fails;
	int                              testsRun;
	int                              n;
	// Implemented bits, register 0 in the low byte
	localparam logic [5:0][7:0] IMPL =
		{8'hF1, 8'hF1, 8'hFF, 8'h67, 8'h7F, 8'hFF};

	pmdb_top dut (.clock(clock), .rst_n(rst_n), .ce(ce), .cyc_i(cyc_i),
		.stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
		.dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.scannerConfigEnable(scan), .zeroCrossConfig(zc),
		.periphOff(periphOff), .periphReady(periphReady),
		.sysClockNetEnable(sysClockNetEnable),
		.instrClockTick(instrClockTick), .nonvolAccessBlock(nvBlock),
		.nonvolCtrlWriteBlock(nvCtrlBlock), .nonvolReady(nvReady));

	always #5 clock = ~clock;

	// ------------------------------------------------------------------
	// Checking and closing
	// ------------------------------------------------------------------
	task automatic check(input string what, input logic [63:0] seen, exp);
		testsRun++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", testsRun, fails);
		if (fails == 0 && testsRun > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	function automatic logic [37:0] expOff(logic [5:0][7:0] r, logic s,
		logic z);
		return {r[0][7:4], r[0][3] | ~s, r[0][2:0], r[1][6:0], r[2][6:5],
			r[2][2:1], r[2][0] & z, r[3][7:4], r[5][7:4], r[3][3:0],
			r[4][7:4], r[4][0], r[5][0]};
	endfunction

	// ------------------------------------------------------------------
	// Bus access
	// ------------------------------------------------------------------
	// Entered just after a rising edge; leaves one idle cycle behind
	task automatic wb(input logic we, input logic [11:0] idx,
		input logic [7:0] wd, input logic sel0);
		int k;
		k = 0;
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i  <= we;
		adr_i <= {2'b00, idx, 2'b00};
		sel_i <= {3'b000, sel0};
		dat_i <= {24'h000000, wd};
		do begin
			@(posedge clock);
			k++;
		end while (ack_o !== 1'b1 && k < 20);
		if (ack_o !== 1'b1) begin
			fails++;
			give_verdict();
		end
		rd = dat_o[7:0];
		check("upper read bits", {40'h0, dat_o[31:8]}, 64'h0);
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i  <= 1'b0;
		@(posedge clock);
		check("ack drop", ack_o, 64'h0);
	endtask

	task automatic wrReg(input int i, input logic [7:0] v);
		wb(1'b1, 12'hEDC + 12'(i), v, 1'b1);
		shadow[i] = v & IMPL[i];
	endtask

	task automatic rdReg(input int i);
		wb(1'b0, 12'hEDC + 12'(i), 8'h00, 1'b1);
		check("register read", rd, shadow[i]);
	endtask

	task automatic chkOff;
		#1;
		check("periphOff", periphOff, expOff(shadow, scan, zc));
		@(posedge clock);
	endtask

	// Counts cycles until the given flag rises, bounded
	task automatic waitReady(input int which);
		n = 0;
		#1;
		while (!((which == 0 && periphReady.timerOff === 7'h7F) ||
			(which == 1 && nvReady === 1'b1)) && n < 200) begin
			@(posedge clock);
			#1;
			n++;
		end
		@(posedge clock);
	endtask

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		clock = 1'b0;
		rst_n = 1'b0;
		ce = 1'b1;
		{cyc_i, stb_i, we_i} = 3'b000;
		adr_i = 16'h0000;
		sel_i = 4'h0;
		dat_i = 32'h00000000;
		scan = 1'b1;
		zc = 1'b1;
		fails = 0;
		testsRun = 0;
		shadow = '0;
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		for (int i = 0; i < 6; i++) rdReg(i);
		chkOff();
		for (int i = 0; i < 6; i++) begin
			for (int b = 0; b < 8; b++) begin
				wrReg(i, 8'h01 << b);
				chkOff();
				rdReg(i);
				wrReg(i, 8'h00);
			end
		end
		for (int i = 0; i < 6; i++) wrReg(i, 8'hFF);
		for (int i = 0; i < 6; i++) rdReg(i);
		chkOff();
		check("clock net", sysClockNetEnable, 64'h0);
		check("mem block", nvBlock, 64'h1);
		check("mem ctrl block", nvCtrlBlock, 64'h1);
		check("ready low", periphReady, 64'h0);
		n = 0;
		for (int c = 0; c < 16; c++) begin
			@(posedge clock);
			#1;
			if (instrClockTick === 1'b1) n++;
		end
		@(posedge clock);
		check("ticks while gated", n, 64'd4);
		wrReg(1, 8'h00);
		waitReady(0);
		check("unit settle", n >= 6 && n <= 9, 64'h1);
		wrReg(0, 8'h00);
		check("clock net back", sysClockNetEnable, 64'h1);
		waitReady(1);
		check("mem settle", n >= 97 && n <= 102, 64'h1);
		for (int i = 2; i < 6; i++) wrReg(i, 8'h00);
		wrReg(2, 8'h01);
		scan <= 1'b0;
		zc <= 1'b0;
		@(posedge clock);
		@(posedge clock);
		chkOff();
		zc <= 1'b1;
		@(posedge clock);
		@(posedge clock);
		chkOff();
		scan <= 1'b1;
		wb(1'b1, 12'hEE2, 8'hFF, 1'b1);
		wb(1'b0, 12'hEE2, 8'h00, 1'b1);
		check("unmapped read", rd, 64'h0);
		wb(1'b1, 12'hEDF, 8'hFF, 1'b0);
		rdReg(3);
		wrReg(3, 8'hFF);
		rst_n <= 1'b0;
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		shadow = '0;
		@(posedge clock);
		rdReg(3);
		rdReg(2);
		give_verdict();
	end
endmodule // pmdb_bench
